// >>> verilog/pmcs_defs.svh
/*
   Constants of the monitor command slave: command codes, format bytes,
   transfer lengths and reset values.
   Assumes inclusion by bare name from the slave design file.
*/
`ifndef PMCS_DEFS_SVH
`define PMCS_DEFS_SVH

// ==========================================================
// Command codes
`define PMCS_CMD_PAGE          8'h00
`define PMCS_CMD_FORMAT_MODE   8'h20
`define PMCS_CMD_READ_UNSIGNED 8'h8b
`define PMCS_CMD_REG_SELECT    8'hd0
`define PMCS_CMD_REG_DATA      8'hd1
`define PMCS_CMD_SUPPLY_MAX    8'hd2
`define PMCS_CMD_SUPPLY_MIN    8'hd3
`define PMCS_CMD_OV_LIMIT      8'hd4
`define PMCS_CMD_UV_LIMIT      8'hd5
`define PMCS_CMD_TEMP_MAX      8'hd6
`define PMCS_CMD_TEMP_MIN      8'hd7
`define PMCS_CMD_CLEAR_TEMP    8'hd8
`define PMCS_CMD_SIGNED_VOLT   8'hd9
`define PMCS_CMD_CLEAR_SUPPLY  8'hda

// ==========================================================
// Format mode bytes: mode 000b in [7:5], exponent in [4:0]
`define PMCS_MODE_UNSIGNED     8'h12
`define PMCS_MODE_SIGNED       8'h11

// ==========================================================
// Data byte counts of write transfers
`define PMCS_LEN_PAGE          3'h1
`define PMCS_LEN_WORD          3'h2
`define PMCS_LEN_REG_DATA      3'h4
`define PMCS_LEN_CLEAR         3'h0

// ==========================================================
// Reset values, bits per byte and data byte count limit
`define PMCS_OV_LIMIT_RST      16'h7fff
`define PMCS_UV_LIMIT_RST      16'h8000
`define PMCS_BITS_PER_BYTE     4'h8
`define PMCS_DATA_MAX          3'h7

`endif

// >>> verilog/pmcs_pkg.sv
/*
   Types of the monitor command slave.
   Assumes nothing beyond a SystemVerilog compiler.
*/
package pmcs_pkg;

   // ==========================================================
   // Byte engine states
   typedef enum logic [2:0] {
      PMCS_IDLE,
      PMCS_RX,
      PMCS_ACK,
      PMCS_TX,
      PMCS_TXACK,
      PMCS_TXGO
   } pmcs_state_e;

endpackage

// >>> verilog/pmcs_slave.sv
/*
   Two-wire command slave of a voltage and temperature monitor: bus
   engine, command execution, min/max history, limits and faults.
   Assumes an external host drives clock and data lines (open drain,
   pulled up outside) and that the monitor core delivers samples
   as one-cycle strobes on mclk.
*/
`timescale 1ns/1ps
`include "pmcs_defs.svh"

// Overview of operation
// RL1: D3h returns lowest recorded signed voltage of the paged supply.
// RL2: D6h and D7h return highest and lowest temperature, exponent format.
// RL3: D4h holds the paged supply's over-voltage limit, read and write.
// RL4: D5h holds the paged supply's under-voltage limit, read and write.
// RL5: Zero-byte D8h clears temperature history; DAh clears all supply history.
// RL6: Signed voltages are 16-bit two's complement times two to minus fifteen.
// RL7: Unsigned voltages are 16-bit times two to minus fourteen.
// RL8: Voltage commands use voltage formats, temperature commands exponent format.
// RL9: Temperature word: bits 15-11 signed exponent, 10-0 signed mantissa.
// RL10: Mode byte is 000b then exponent: minus fourteen or minus fifteen.
// RL11: Host opens with start, changes direction by repeated start.
// RL12: Host sends 7-bit address then direction bit, one means read.
// RL13: Host sends command byte; device acknowledges each received byte low.
// RL14: Host acks reads low, nacks high, ends with stop.
// RL15: Register writes arrive byte by byte, most significant first, acked.
// RL16: Register reads leave byte by byte, most significant first.
// RL17: Data words after a select command form a register address.
// RL18: D1h reads or writes four bytes of the selected register.
// RL19: On a host nack the device stops driving and releases the bus.
// RL20: Page commands use the last page; common commands ignore it.
module pmcs_slave
   import pmcs_pkg::*;
#(
   parameter logic [6:0] SLAVE_ADDR = 7'h32,
   parameter int         NSUP       = 4,
   parameter int         PW         = $clog2(NSUP)
) (
   // Clock and reset
   input  wire logic          mclk,
   input  wire logic          rstn,
   // Bus pins, data line open drain
   input  wire logic          sclIn,
   input  wire logic          sdaIn,
   output      logic          sdaOut,
   output      logic          sdaOe,
   // Supply samples, signed format
   input  wire logic          supplyValid,
   input  wire logic [PW-1:0] supplyIdx,
   input  wire logic [15:0]   supplyVolt,
   // Temperature samples, exponent format
   input  wire logic          tempValid,
   input  wire logic [15:0]   tempWord,
   // Internal register port
   output      logic [15:0]   regSelect,
   output      logic [31:0]   regWdata,
   output      logic          regWrite,
   input  wire logic [31:0]   regRdata,
   // Limit faults per supply
   output      logic [NSUP-1:0] ovFault,
   output      logic [NSUP-1:0] uvFault
);

   localparam logic [7:0] NSUP8 = 8'(NSUP);

   // ==========================================================
   // Pin synchronisers and glitch filter
   logic [2:0]  sclS, next_sclS;
   logic [2:0]  sdaS, next_sdaS;
   logic        sclF, next_sclF;
   logic        sdaF, next_sdaF;
   logic        sclP;
   logic        sdaP;
   logic        sclRise;
   logic        sclFall;
   logic        startEv;
   logic        stopEv;

   // A change counts only when stages two and three agree
   always_comb begin
      next_sclS = {sclS[1:0], sclIn};
      next_sdaS = {sdaS[1:0], sdaIn};
      next_sclF = (sclS[1] == sclS[2]) ? sclS[2] : sclF;
      next_sdaF = (sdaS[1] == sdaS[2]) ? sdaS[2] : sdaF;
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         sclS <= 3'h7;
         sdaS <= 3'h7;
         sclF <= 1'b1;
         sdaF <= 1'b1;
         sclP <= 1'b1;
         sdaP <= 1'b1;
      end else begin
         sclS <= next_sclS;
         sdaS <= next_sdaS;
         sclF <= next_sclF;
         sdaF <= next_sdaF;
         sclP <= sclF;
         sdaP <= sdaF;
      end
   end

   // Bus events from the filtered lines
   assign sclRise = sclF & ~sclP;
   assign sclFall = ~sclF & sclP;
   assign startEv = sclF & sclP & sdaP & ~sdaF;
   assign stopEv  = sclF & sclP & ~sdaP & sdaF;
   assign sdaOut  = 1'b0;

   // ==========================================================
   // Byte engine
   pmcs_state_e state, next_state;
   logic [3:0]  bitCnt, next_bitCnt;
   logic [7:0]  shReg, next_shReg;
   logic        addrPhase, next_addrPhase;
   logic        isRead, next_isRead;
   logic        haveCmd, next_haveCmd;
   logic        wrPend, next_wrPend;
   logic [7:0]  cmd, next_cmd;
   logic [2:0]  nData, next_nData;
   logic [31:0] wbuf, next_wbuf;
   logic [31:0] txBuf, next_txBuf;
   logic        next_sdaOe;
   logic        commit;
   logic [31:0] txWord;

   always_comb begin
      next_state     = state;
      next_bitCnt    = bitCnt;
      next_shReg     = shReg;
      next_addrPhase = addrPhase;
      next_isRead    = isRead;
      next_haveCmd   = haveCmd;
      next_wrPend    = wrPend;
      next_cmd       = cmd;
      next_nData     = nData;
      next_wbuf      = wbuf;
      next_txBuf     = txBuf;
      next_sdaOe     = sdaOe;
      commit         = 1'b0;
      // RL11 framing: start or stop ends any write phase
      if (startEv || stopEv) begin
         commit         = wrPend;
         next_wrPend    = 1'b0;
         next_state     = startEv ? PMCS_RX : PMCS_IDLE;
         next_bitCnt    = 4'h0;
         next_addrPhase = 1'b1;
         next_sdaOe     = 1'b0;
      end else begin
         case (state)
            PMCS_RX: begin
               if (sclRise) begin
                  next_shReg  = {shReg[6:0], sdaF};
                  next_bitCnt = bitCnt + 4'h1;
               end else if (sclFall && bitCnt == `PMCS_BITS_PER_BYTE) begin
                  next_bitCnt = 4'h0;
                  if (addrPhase) begin
                     // RL12 address match
                     if (shReg[7:1] == SLAVE_ADDR) begin
                        next_sdaOe     = 1'b1;
                        next_isRead    = shReg[0];
                        next_addrPhase = 1'b0;
                        next_state     = PMCS_ACK;
                        if (!shReg[0]) begin
                           next_haveCmd = 1'b0;
                           next_nData   = 3'h0;
                        end
                     end else begin
                        next_state = PMCS_IDLE;
                     end
                  end else begin
                     // RL13 ack every byte
                     next_sdaOe  = 1'b1;
                     next_state  = PMCS_ACK;
                     next_wrPend = 1'b1;
                     if (!haveCmd) begin
                        next_cmd     = shReg;
                        next_haveCmd = 1'b1;
                     end else begin
                        // RL15 most significant first
                        next_wbuf = {wbuf[23:0], shReg};
                        if (nData != `PMCS_DATA_MAX) begin
                           next_nData = nData + 3'h1;
                        end
                     end
                  end
               end
            end
            PMCS_ACK: begin
               if (sclFall) begin
                  if (isRead) begin
                     next_state  = PMCS_TX;
                     next_sdaOe  = ~txWord[31];
                     next_txBuf  = {txWord[30:0], 1'b0};
                     next_bitCnt = 4'h1;
                  end else begin
                     next_state = PMCS_RX;
                     next_sdaOe = 1'b0;
                  end
               end
            end
            PMCS_TX: begin
               if (sclFall) begin
                  if (bitCnt == `PMCS_BITS_PER_BYTE) begin
                     next_sdaOe  = 1'b0;
                     next_state  = PMCS_TXACK;
                     next_bitCnt = 4'h0;
                  end else begin
                     next_sdaOe  = ~txBuf[31];
                     next_txBuf  = {txBuf[30:0], 1'b0};
                     next_bitCnt = bitCnt + 4'h1;
                  end
               end
            end
            PMCS_TXACK: begin
               // RL19 release on host nack
               if (sclRise) begin
                  next_state = sdaF ? PMCS_IDLE : PMCS_TXGO;
               end
            end
            PMCS_TXGO: begin
               // RL16 next byte of the word
               if (sclFall) begin
                  next_state  = PMCS_TX;
                  next_sdaOe  = ~txBuf[31];
                  next_txBuf  = {txBuf[30:0], 1'b0};
                  next_bitCnt = 4'h1;
               end
            end
            PMCS_IDLE: begin
               next_sdaOe = 1'b0;
            end
            default: begin
               next_state = PMCS_IDLE;
               next_sdaOe = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state     <= PMCS_IDLE;
         bitCnt    <= 4'h0;
         shReg     <= 8'h00;
         addrPhase <= 1'b1;
         isRead    <= 1'b0;
         haveCmd   <= 1'b0;
         wrPend    <= 1'b0;
         cmd       <= 8'h00;
         nData     <= 3'h0;
         wbuf      <= 32'h0;
         txBuf     <= 32'h0;
         sdaOe     <= 1'b0;
      end else begin
         state     <= next_state;
         bitCnt    <= next_bitCnt;
         shReg     <= next_shReg;
         addrPhase <= next_addrPhase;
         isRead    <= next_isRead;
         haveCmd   <= next_haveCmd;
         wrPend    <= next_wrPend;
         cmd       <= next_cmd;
         nData     <= next_nData;
         wbuf      <= next_wbuf;
         txBuf     <= next_txBuf;
         sdaOe     <= next_sdaOe;
      end
   end

   // ==========================================================
   // Monitor state: page, limits, history
   logic [7:0]  page, next_page;
   logic [15:0] curV [NSUP];
   logic [15:0] minV [NSUP];
   logic [15:0] maxV [NSUP];
   logic [15:0] ovLim [NSUP];
   logic [15:0] uvLim [NSUP];
   logic [15:0] next_curV [NSUP];
   logic [15:0] next_minV [NSUP];
   logic [15:0] next_maxV [NSUP];
   logic [15:0] next_ovLim [NSUP];
   logic [15:0] next_uvLim [NSUP];
   logic [NSUP-1:0] sVal, next_sVal;
   logic [NSUP-1:0] next_ovFault;
   logic [NSUP-1:0] next_uvFault;
   logic [15:0] tMax, next_tMax;
   logic [15:0] tMin, next_tMin;
   logic        tVal, next_tVal;
   logic [15:0] next_regSelect;
   logic [31:0] next_regWdata;
   logic        next_regWrite;
   logic [PW-1:0] pg;

   // RL20 paged commands index by the low page bits
   assign pg = page[PW-1:0];

   // RL9 temperature word to a comparable fixed-point value
   function automatic logic signed [47:0] l11Value(input logic [15:0] w);
      logic signed [47:0] m;
      logic [4:0]         sh;
      m  = {{21{w[10]}}, w[10:0], 16'h0000};
      sh = 5'(~w[15:11] + 5'h1);
      if (w[15]) begin
         l11Value = m >>> sh;
      end else begin
         l11Value = m <<< w[15:11];
      end
   endfunction

   // Words leave low byte first, register data most significant first
   function automatic logic [31:0] wordOut(input logic [15:0] x);
      wordOut = {x[7:0], x[15:8], 16'h0000};
   endfunction

   // Read data selected by the held command
   always_comb begin
      case (cmd)
         `PMCS_CMD_PAGE:          txWord = {page, 24'h0};
         // RL10 mode byte of the unsigned format
         `PMCS_CMD_FORMAT_MODE:   txWord = {`PMCS_MODE_UNSIGNED, 24'h0};
         // RL7 signed to unsigned, negatives read as zero
         `PMCS_CMD_READ_UNSIGNED: txWord = wordOut(curV[pg][15] ? 16'h0 :
                                                   {1'b0, curV[pg][15:1]});
         // RL17 selected register address
         `PMCS_CMD_REG_SELECT:    txWord = {regSelect, 16'h0};
         // RL18 four register bytes
         `PMCS_CMD_REG_DATA:      txWord = regRdata;
         `PMCS_CMD_SUPPLY_MAX:    txWord = wordOut(maxV[pg]);
         // RL1 lowest supply voltage
         `PMCS_CMD_SUPPLY_MIN:    txWord = wordOut(minV[pg]);
         // RL3 over-voltage limit readback
         `PMCS_CMD_OV_LIMIT:      txWord = wordOut(ovLim[pg]);
         // RL4 under-voltage limit readback
         `PMCS_CMD_UV_LIMIT:      txWord = wordOut(uvLim[pg]);
         // RL2 temperature history, RL8 exponent format
         `PMCS_CMD_TEMP_MAX:      txWord = wordOut(tMax);
         `PMCS_CMD_TEMP_MIN:      txWord = wordOut(tMin);
         // RL6 signed measured voltage
         `PMCS_CMD_SIGNED_VOLT:   txWord = wordOut(curV[pg]);
         default:                 txWord = 32'h0;
      endcase
   end

   // Commands first, then samples, so a sample never loses to a clear
   always_comb begin
      next_page      = page;
      next_curV      = curV;
      next_minV      = minV;
      next_maxV      = maxV;
      next_ovLim     = ovLim;
      next_uvLim     = uvLim;
      next_sVal      = sVal;
      next_ovFault   = ovFault;
      next_uvFault   = uvFault;
      next_tMax      = tMax;
      next_tMin      = tMin;
      next_tVal      = tVal;
      next_regSelect = regSelect;
      next_regWdata  = regWdata;
      next_regWrite  = 1'b0;
      if (commit && haveCmd) begin
         case (cmd)
            `PMCS_CMD_PAGE: begin
               if (nData == `PMCS_LEN_PAGE && wbuf[7:0] < NSUP8) begin
                  next_page = wbuf[7:0];
               end
            end
            `PMCS_CMD_REG_SELECT: begin
               if (nData == `PMCS_LEN_WORD) begin
                  next_regSelect = wbuf[15:0];
               end
            end
            `PMCS_CMD_REG_DATA: begin
               if (nData == `PMCS_LEN_REG_DATA) begin
                  next_regWdata = wbuf;
                  next_regWrite = 1'b1;
               end
            end
            // RL3 over-voltage limit write
            `PMCS_CMD_OV_LIMIT: begin
               if (nData == `PMCS_LEN_WORD) begin
                  next_ovLim[pg] = {wbuf[7:0], wbuf[15:8]};
               end
            end
            // RL4 under-voltage limit write
            `PMCS_CMD_UV_LIMIT: begin
               if (nData == `PMCS_LEN_WORD) begin
                  next_uvLim[pg] = {wbuf[7:0], wbuf[15:8]};
               end
            end
            // RL5 temperature history clear
            `PMCS_CMD_CLEAR_TEMP: begin
               if (nData == `PMCS_LEN_CLEAR) begin
                  next_tVal = 1'b0;
               end
            end
            // RL5 supply history clear
            `PMCS_CMD_CLEAR_SUPPLY: begin
               if (nData == `PMCS_LEN_CLEAR) begin
                  next_sVal = '0;
               end
            end
            default: begin
            end
         endcase
      end
      // RL6 signed compare of supply samples
      if (supplyValid) begin
         next_curV[supplyIdx] = supplyVolt;
         if (!next_sVal[supplyIdx] ||
             $signed(supplyVolt) < $signed(minV[supplyIdx])) begin
            next_minV[supplyIdx] = supplyVolt;
         end
         if (!next_sVal[supplyIdx] ||
             $signed(supplyVolt) > $signed(maxV[supplyIdx])) begin
            next_maxV[supplyIdx] = supplyVolt;
         end
         next_sVal[supplyIdx]    = 1'b1;
         next_ovFault[supplyIdx] = $signed(supplyVolt) > $signed(next_ovLim[supplyIdx]);
         next_uvFault[supplyIdx] = $signed(supplyVolt) < $signed(next_uvLim[supplyIdx]);
      end
      // RL2 temperature min and max tracking
      if (tempValid) begin
         if (!next_tVal || l11Value(tempWord) > l11Value(tMax)) begin
            next_tMax = tempWord;
         end
         if (!next_tVal || l11Value(tempWord) < l11Value(tMin)) begin
            next_tMin = tempWord;
         end
         next_tVal = 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         page      <= 8'h00;
         sVal      <= '0;
         ovFault   <= '0;
         uvFault   <= '0;
         tMax      <= 16'h0;
         tMin      <= 16'h0;
         tVal      <= 1'b0;
         regSelect <= 16'h0;
         regWdata  <= 32'h0;
         regWrite  <= 1'b0;
         for (int i = 0; i < NSUP; i++) begin
            curV[i]  <= 16'h0;
            minV[i]  <= 16'h0;
            maxV[i]  <= 16'h0;
            ovLim[i] <= `PMCS_OV_LIMIT_RST;
            uvLim[i] <= `PMCS_UV_LIMIT_RST;
         end
      end else begin
         page      <= next_page;
         sVal      <= next_sVal;
         ovFault   <= next_ovFault;
         uvFault   <= next_uvFault;
         tMax      <= next_tMax;
         tMin      <= next_tMin;
         tVal      <= next_tVal;
         regSelect <= next_regSelect;
         regWdata  <= next_regWdata;
         regWrite  <= next_regWrite;
         curV      <= next_curV;
         minV      <= next_minV;
         maxV      <= next_maxV;
         ovLim     <= next_ovLim;
         uvLim     <= next_uvLim;
      end
   end

endmodule

// >>> verification/pmcs_slave_chk.sv
/*
   Checker of the command slave pins and outputs.
   Assumes binding to pmcs_slave; sees its ports only.
*/
`timescale 1ns/1ps
module pmcs_slave_chk #(
   parameter int NSUP = 4,
   parameter int PW   = 2
) (
   // Clock and reset
   input wire logic            mclk,
   input wire logic            rstn,
   // Bus pins
   input wire logic            sclIn,
   input wire logic            sdaOut,
   input wire logic            sdaOe,
   // Samples, register port and faults
   input wire logic            supplyValid,
   input wire logic [PW-1:0]   supplyIdx,
   input wire logic [31:0]     regWdata,
   input wire logic            regWrite,
   input wire logic [NSUP-1:0] ovFault,
   input wire logic [NSUP-1:0] uvFault
);
   // ==========================================================
   // Helpers
   logic [3:0]      hiCnt;
   logic [3:0]      next_hiCnt;
   logic [NSUP-1:0] lastMask;
   logic [NSUP-1:0] next_lastMask;

   // High-time of scl saturates so idle stretches never wrap
   always_comb begin
      next_hiCnt    = sclIn ? hiCnt + {3'h0, hiCnt != 4'hf} : 4'h0;
      next_lastMask = supplyValid ? NSUP'(1) << supplyIdx : '0;
   end
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         hiCnt    <= 4'h0;
         lastMask <= '0;
      end else begin
         hiCnt    <= next_hiCnt;
         lastMask <= next_lastMask;
      end
   end

   // ==========================================================
   // Properties
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   sequence holdDrive;
      sdaOe [*8];
   endsequence

   chk_drive_zero: assert property (sdaOut == 1'h0)
      else $error("data drive value not zero");
   chk_oe_scl_low: assert property ($changed(sdaOe) |-> !sclIn)
      else $error("data drive changed while clock high");
   chk_oe_hold: assert property ($rose(sdaOe) |-> holdDrive)
      else $error("data drive shorter than one bit");
   chk_ack_delay: assert property ($rose(sdaOe) |-> $past(!sclIn, 1) && $past(!sclIn, 3))
      else $error("data drive began too soon after clock fall");
   chk_fault_other: assert property ((((ovFault ^ $past(ovFault))
      | (uvFault ^ $past(uvFault))) & ~lastMask) == '0)
      else $error("fault changed without its sample");
   chk_wdata_strobe: assert property ($changed(regWdata) |-> ##[0:1] regWrite)
      else $error("write data changed without strobe");
   chk_write_idle: assert property (regWrite |-> !sdaOe ##1 !regWrite)
      else $error("register write during drive or too long");
   chk_idle_release: assert property (hiCnt >= 4'ha |-> !sdaOe)
      else $error("data line held with bus idle");
endmodule

bind pmcs_slave pmcs_slave_chk #(.NSUP(NSUP), .PW(PW)) i_pmcs_slave_chk (.mclk, .rstn,
   .sclIn, .sdaOut, .sdaOe, .supplyValid, .supplyIdx, .regWdata, .regWrite, .ovFault, .uvFault);

// >>> verification/pmcs_host.sv
/*
   Host model of the two-wire bus: frames, bytes and ack slots.
   Assumes a pulled-up data wire fed back on sda; 12 mclk per bit.
*/
`timescale 1ns/1ps
module pmcs_host (
   // Clock and wire level
   input  wire logic       mclk,
   input  wire logic       sda,
   // Host pins
   output      logic       scl,
   output      logic       hostOe,
   // Nine wire bits of each byte slot
   output      logic       gotByte,
   output      logic [8:0] gotVal
);
   // Clock stands high outside frames
   initial begin
      scl     = 1'h1;
      hostOe  = 1'h0;
      gotByte = 1'h0;
      gotVal  = 9'h0;
   end
   task automatic tk(input int n);
      repeat (n) @(posedge mclk);
   endtask
   // start or repeated start (o high), stop (o low)
   task automatic cond(input logic o);
      scl <= 1'h0;
      tk(3);
      hostOe <= !o;
      tk(3);
      scl <= 1'h1;
      tk(3);
      hostOe <= o;
      tk(6);
   endtask
   // Data changes mid-low, sampled mid-high
   task automatic bitx(input logic b, output logic r);
      scl <= 1'h0;
      tk(3);
      hostOe <= !b;
      tk(3);
      scl <= 1'h1;
      tk(3);
      @(negedge mclk) r = sda;
      tk(3);
   endtask
   // byte MSB first, then ack slot
   task automatic xbyte(input logic [7:0] d, input logic a);
      logic [8:0] v;
      for (int i = 7; i >= 0; i--) bitx(d[i], v[i]);
      bitx(a, v[8]);
      gotVal  <= v;
      gotByte <= 1'h1;
      tk(1);
      gotByte <= 1'h0;
   endtask
endmodule

// >>> verification/pmcs_slave_tb.sv
/*
   Testbench of the command slave with host model and driven samples.
   Assumes the host model and bound checker are compiled.
*/
`timescale 1ns/1ps
module pmcs_slave_tb;
   localparam logic [6:0] ADR = 7'h32;
   logic mclk = 1'h0, rstn = 1'h0, supplyValid = 1'h0, tempValid = 1'h0;
   logic [1:0]  supplyIdx = 2'h0;
   logic [15:0] supplyVolt = 16'h0, tempWord = 16'h0, regSelect;
   logic [31:0] regRdata = 32'h0, regWdata, rnd = 32'h000148f6;
   logic [3:0]  ovFault, uvFault;
   logic        sdaOut, sdaOe, regWrite, scl, hostOe, gotByte, sdaWire;
   logic [8:0]  gotVal;
   logic signed [15:0] mn, mx, v;
   logic [31:0] expQ[$], wrQ[$];
   int          error_cnt = 0, n_checks = 0, cyc = 0;

   // Open-drain wire with pull-up
   assign sdaWire = ~(sdaOe | hostOe);
   always #2 mclk = ~mclk;

   pmcs_slave #(.SLAVE_ADDR(ADR)) i_pmcs_slave (.mclk, .rstn, .sclIn(scl), .sdaIn(sdaWire),
      .sdaOut, .sdaOe, .supplyValid, .supplyIdx, .supplyVolt, .tempValid, .tempWord,
      .regSelect, .regWdata, .regWrite, .regRdata, .ovFault, .uvFault);
   pmcs_host i_pmcs_host (.mclk, .sda(sdaWire), .scl, .hostOe, .gotByte, .gotVal);

   // ==========================================================
   // Helpers
   function automatic logic [31:0] nx(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Words travel low byte first
   function automatic logic [31:0] w(input logic [15:0] x);
      return {x[7:0], x[15:8], 16'h0};
   endfunction
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic finish_test();
      if (expQ.size() != 0 || wrQ.size() != 0) error_cnt++;
      if (error_cnt == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic tk(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic send(input logic [7:0] d, input logic nak);
      expQ.push_back({23'h0, nak, d});
      i_pmcs_host.xbyte(d, 1'h1);
   endtask
   // One frame: write bytes, then optional read after repeated start
   task automatic xfer(input logic [7:0] c, input int nw, input logic [31:0] wd,
                       input int nr = 0, input logic [31:0] rd = 32'h0,
                       input logic [6:0] a = ADR);
      logic nak;
      nak = (a != ADR);
      i_pmcs_host.cond(1'h1);
      send({a, 1'h0}, nak);
      send(c, nak);
      for (int i = 0; i < nw; i++) send(wd[31-8*i -: 8], nak);
      if (nr > 0) begin
         i_pmcs_host.cond(1'h1);
         send({ADR, 1'h1}, 1'h0);
         for (int i = 0; i < nr; i++) begin
            expQ.push_back({23'h0, i == nr - 1, rd[31-8*i -: 8]});
            i_pmcs_host.xbyte(8'hff, i == nr - 1);
         end
      end
      i_pmcs_host.cond(1'h0);
   endtask
   // One sample strobe, supply or temperature
   task automatic smp(input logic t, input logic [1:0] i, input logic [15:0] d);
      {supplyValid, tempValid} <= {!t, t};
      supplyIdx   <= i;
      supplyVolt  <= d;
      tempWord    <= d;
      tk(1);
      {supplyValid, tempValid} <= 2'h0;
      tk(2);
   endtask

   // ==========================================================
   // Monitor: oldest note against each result
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (gotByte === 1'h1) check("bus byte", {23'h0, gotVal},
         expQ.size() > 0 ? expQ.pop_front() : 32'hffffffff);
      if (regWrite === 1'h1) check("regWdata", regWdata,
         wrQ.size() > 0 ? wrQ.pop_front() : ~regWdata);
      if (cyc == 30000) begin
         error_cnt++;
         finish_test();
      end
   end

   // ==========================================================
   // Main sequence
   initial begin
      tk(16);
      rstn <= 1'h1;
      tk(10);
      xfer(8'hd3, 0, 0, 0, 0, ADR ^ 7'h01);
      xfer(8'h20, 0, 0, 1, 32'h12000000);
      xfer(8'hd0, 2, 32'habcd0000);
      check("regSelect", {16'h0, regSelect}, 32'h0000abcd);
      rnd = nx(rnd);
      wrQ.push_back(rnd);
      xfer(8'hd1, 4, rnd);
      xfer(8'hd1, 3, rnd);
      rnd = nx(rnd);
      regRdata <= rnd;
      xfer(8'hd1, 0, 0, 4, rnd);
      xfer(8'h00, 1, 32'h01000000);
      mn = 16'sh7fff;
      mx = 16'sh8000;
      for (int k = 0; k < 4; k++) begin
         rnd = nx(rnd);
         v = rnd[15:0];
         smp(1'h0, 2'h1, v);
         if (v < mn) mn = v;
         if (v > mx) mx = v;
      end
      smp(1'h0, 2'h2, 16'h8000);
      smp(1'h0, 2'h2, 16'h7fff);
      xfer(8'h00, 1, 32'h05000000);
      xfer(8'hd3, 0, 0, 2, w(mn));
      xfer(8'hd2, 0, 0, 2, w(mx));
      xfer(8'hd9, 0, 0, 2, w(v));
      xfer(8'h8b, 0, 0, 2, w(v[15] ? 16'h0 : {1'h0, v[15:1]}));
      xfer(8'hd4, 2, w(16'h4000));
      xfer(8'hd4, 0, 0, 2, w(16'h4000));
      smp(1'h0, 2'h1, 16'h5000);
      check("ovFault", {28'h0, ovFault}, 32'h2);
      xfer(8'hd5, 2, w(16'hc000));
      xfer(8'hd5, 0, 0, 2, w(16'hc000));
      smp(1'h0, 2'h1, 16'hb000);
      check("faults", {24'h0, ovFault, uvFault}, 32'h02);
      xfer(8'hda, 0, 0);
      smp(1'h0, 2'h1, 16'h0123);
      xfer(8'hd3, 0, 0, 2, w(16'h0123));
      xfer(8'hd2, 0, 0, 2, w(16'h0123));
      smp(1'h1, 2'h0, 16'h0050);
      smp(1'h1, 2'h0, 16'h07ec);
      smp(1'h1, 2'h0, 16'hea81);
      xfer(8'hd6, 0, 0, 2, w(16'hea81));
      xfer(8'hd7, 0, 0, 2, w(16'h07ec));
      xfer(8'hd8, 0, 0);
      smp(1'h1, 2'h0, 16'h0019);
      xfer(8'hd6, 0, 0, 2, w(16'h0019));
      xfer(8'hd7, 0, 0, 2, w(16'h0019));
      tk(4);
      finish_test();
   end
endmodule
